/* File: hdl/evp_prioritizer.sv */
// Exception source arbitration, masking and vector fetch for a small core.
// Assumes core reports instruction boundaries and trap execution, and a byte
// vector memory that answers one cycle after the edge that samples a read.
//
// Operation
// - Reset outranks everything; vector 0 fetch starts right at reset release.
// - Watchdog overflow resets the chip and runs the same reset sequence.
// - Trap number 0 to 3 selects vector 8 to 11.
// - Trap is accepted regardless of the interrupt mask bit.
// - Mask bit set holds off all interrupts but NMI and address break.
// - Pending interrupts are taken only at an instruction boundary.
// - Several pending: lowest vector number, highest priority, served first.
// - Table: NMI 7, address break 12, external pins 14-17, wakeup 18.
// - Vectors 1 to 6, 19 and 20 are never assigned.
// - Sleep direct transition raises vector 13.
// - External pin 0 and low-voltage detect share vector 14.
// - Compare timer A, B and overflow share vector 22.
// - First serial channel events share vector 23.
// - Two-wire bus unit events share vector 24.
// - Converter 25, multi-function timer ch0 26, ch1 27, reload timer 29.
// - Second serial channel events share vector 32, lowest priority.
// - External pins detect falling edge on select 0, rising on 1.
// - Wakeup requests pass only while the shared wakeup enable is 1.
`timescale 1ns/100ps
`default_nettype none

module evp_prioritizer
  import evp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            wdt_overflow,
  input  wire logic            cpu_boundary,
  input  wire logic            ccr_i_mask,
  input  wire logic            trap_exec,
  input  wire logic [1:0]      trap_num,
  input  wire logic            nmi_req,
  input  wire logic            addr_break_req,
  input  wire logic            sleep_direct_req,
  input  wire logic            low_voltage_req,
  input  wire evp_pins_t       pins,
  input  wire evp_periph_req_t periph,
  input  wire logic [7:0]      mem_rdata,
  output evp_mem_req_t         mem_req_ff,
  output evp_pc_load_t         pc_load_ff,
  output logic [5:0]           vec_num_ff,
  output logic                 svc_ack_ff,
  output logic                 exc_busy_ff,
  output logic                 chip_reset_ff
);

  evp_state_t            state_ff;
  logic [7:0]            hi_byte_ff;
  logic                  nmi_pend_ff;
  logic                  abrk_pend_ff;
  logic                  sleep_pend_ff;
  logic                  lvd_pend_ff;
  logic                  trap_pend_ff;
  logic [1:0]            trap_num_ff;
  logic [EVP_NEXT-1:0]   ext_pend_ff;
  logic                  wake_pend_ff;
  logic [EVP_NEXT-1:0]   ext_edge;
  logic [EVP_NWAKE-1:0]  wake_edge;
  logic [EVP_NVEC-1:0]   req;
  logic                  found;
  logic [5:0]            win_vec;
  logic                  take;
  logic [5:0]            trap_vec;

  // Pin edge detection lives in a shared leaf
  evp_edge_det #(.W(EVP_NEXT)) u_ext_edge (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (pins.ext),
    .rise_sel (pins.ext_sel),
    .edge_ff  (ext_edge)
  );

  evp_edge_det #(.W(EVP_NWAKE)) u_wake_edge (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin      (pins.wake),
    .rise_sel (pins.wake_sel),
    .edge_ff  (wake_edge)
  );

  assign trap_vec = VEC_TRAP0 + {4'h0, trap_num_ff};

  // Request vector indexed by vector number; unlisted slots stay zero
  always_comb begin
    req = '0;
    req[VEC_NMI] = nmi_pend_ff;
    req[VEC_ABRK] = abrk_pend_ff;
    if (trap_pend_ff) begin
      req[trap_vec] = 1'b1;
    end
    if (!ccr_i_mask) begin
      req[VEC_SLEEP] = sleep_pend_ff;
      req[VEC_EXT0] = ext_pend_ff[0] | lvd_pend_ff;
      for (int i = 1; i < EVP_NEXT; i++) begin
        req[VEC_EXT0 + 6'(i)] = ext_pend_ff[i];
      end
      req[VEC_WAKE] = wake_pend_ff;
      req[VEC_CMPT] = |periph.cmp_timer;
      req[VEC_SER1] = |periph.serial1;
      req[VEC_TWB] = |periph.two_wire;
      req[VEC_ADC] = periph.adc_end;
      req[VEC_MTU0] = |periph.mtu_ch0;
      req[VEC_MTU1] = |periph.mtu_ch1;
      req[VEC_RLD] = periph.reload_ovf;
      req[VEC_SER2] = |periph.serial2;
    end
  end

  // Lowest set index wins; scanning downward lets the smallest overwrite
  always_comb begin
    found = 1'b0;
    win_vec = VEC_RESET;
    for (int i = EVP_NVEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        win_vec = 6'(i);
      end
    end
  end

  // Grant only between instructions and when no sequence is running
  assign take = (state_ff == EVP_IDLE) && cpu_boundary && found && !wdt_overflow;

  // Latched pulse sources; a new event in the grant cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_ff   <= 1'b0;
      abrk_pend_ff  <= 1'b0;
      sleep_pend_ff <= 1'b0;
      lvd_pend_ff   <= 1'b0;
      ext_pend_ff   <= '0;
      wake_pend_ff  <= 1'b0;
    end else if (wdt_overflow) begin
      nmi_pend_ff   <= 1'b0;
      abrk_pend_ff  <= 1'b0;
      sleep_pend_ff <= 1'b0;
      lvd_pend_ff   <= 1'b0;
      ext_pend_ff   <= '0;
      wake_pend_ff  <= 1'b0;
    end else begin
      nmi_pend_ff   <= (nmi_pend_ff & ~(take && win_vec == VEC_NMI)) | nmi_req;
      abrk_pend_ff  <= (abrk_pend_ff & ~(take && win_vec == VEC_ABRK)) | addr_break_req;
      sleep_pend_ff <= (sleep_pend_ff & ~(take && win_vec == VEC_SLEEP)) | sleep_direct_req;
      lvd_pend_ff   <= (lvd_pend_ff & ~(take && win_vec == VEC_EXT0)) | low_voltage_req;
      for (int i = 0; i < EVP_NEXT; i++) begin
        ext_pend_ff[i] <= (ext_pend_ff[i] & ~(take && win_vec == VEC_EXT0 + 6'(i)))
                          | ext_edge[i];
      end
      wake_pend_ff  <= (wake_pend_ff & ~(take && win_vec == VEC_WAKE))
                       | (pins.wake_en & (|wake_edge));
    end
  end

  // Trap latch keeps the trap number until its vector is granted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_pend_ff <= 1'b0;
      trap_num_ff  <= 2'h0;
    end else if (wdt_overflow) begin
      trap_pend_ff <= 1'b0;
    end else if (trap_exec) begin
      trap_pend_ff <= 1'b1;
      trap_num_ff  <= trap_num;
    end else if (take && win_vec == trap_vec) begin
      trap_pend_ff <= 1'b0;
    end
  end

  // Fetch sequencer; reset state is the vector 0 fetch, so it starts at release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= EVP_ISSUE_HI;
      vec_num_ff <= VEC_RESET;
    end else if (wdt_overflow) begin
      state_ff   <= EVP_ISSUE_HI;
      vec_num_ff <= VEC_RESET;
    end else begin
      case (state_ff)
        EVP_IDLE: begin
          if (take) begin
            state_ff   <= EVP_ISSUE_HI;
            vec_num_ff <= win_vec;
          end
        end
        EVP_ISSUE_HI: state_ff <= EVP_ISSUE_LO;
        EVP_ISSUE_LO: state_ff <= EVP_TAKE_HI;
        EVP_TAKE_HI:  state_ff <= EVP_TAKE_LO;
        EVP_TAKE_LO:  state_ff <= EVP_IDLE;
        default:      state_ff <= EVP_IDLE;
      endcase
    end
  end

  // Two byte reads of the entry, high byte at the even address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_ff <= '0;
    end else if (wdt_overflow) begin
      mem_req_ff <= '0;
    end else if (state_ff == EVP_ISSUE_HI) begin
      mem_req_ff <= '{rd: 1'b1, addr: evp_vec_addr(vec_num_ff)};
    end else if (state_ff == EVP_ISSUE_LO) begin
      mem_req_ff <= '{rd: 1'b1, addr: evp_vec_addr(vec_num_ff) + ADDR_NEXT_BYTE};
    end else begin
      mem_req_ff <= '{rd: 1'b0, addr: mem_req_ff.addr};
    end
  end

  // Assemble and hand the target to the core as a one-cycle load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_byte_ff <= 8'h00;
      pc_load_ff <= '{load: 1'b0, target: PC_RESET_VAL};
    end else if (wdt_overflow) begin
      pc_load_ff <= '{load: 1'b0, target: pc_load_ff.target};
    end else begin
      if (state_ff == EVP_TAKE_HI) begin
        hi_byte_ff <= mem_rdata;
      end
      if (state_ff == EVP_TAKE_LO) begin
        pc_load_ff <= '{load: 1'b1, target: {hi_byte_ff, mem_rdata}};
      end else begin
        pc_load_ff <= '{load: 1'b0, target: pc_load_ff.target};
      end
    end
  end

  // Status pulses; busy covers the whole fetch so the core stalls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      svc_ack_ff    <= 1'b0;
      exc_busy_ff   <= 1'b1;
      chip_reset_ff <= 1'b0;
    end else begin
      svc_ack_ff    <= take;
      chip_reset_ff <= wdt_overflow;
      exc_busy_ff   <= wdt_overflow || take
                       || (state_ff != EVP_IDLE && state_ff != EVP_TAKE_LO);
    end
  end

  // Checks
  wdt_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_overflow |=> chip_reset_ff ##1 (mem_req_ff.rd && mem_req_ff.addr == ADDR_RESET))
    else $error("watchdog did not restart the reset fetch");

  reset_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_overflow |=> (vec_num_ff == VEC_RESET && !svc_ack_ff))
    else $error("reset did not outrank a pending request");

  trap_vector_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && trap_pend_ff && !nmi_pend_ff) |=> (vec_num_ff == $past(trap_vec)))
    else $error("trap granted on wrong vector");

  trap_unmasked_a: assert property (@(posedge clk) disable iff (!rst_n)
    (trap_pend_ff && ccr_i_mask && take && !nmi_pend_ff) |=> svc_ack_ff
      && vec_num_ff >= VEC_TRAP0 && vec_num_ff < VEC_ABRK)
    else $error("trap held off by mask");

  mask_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (svc_ack_ff && $past(ccr_i_mask)) |-> vec_num_ff <= VEC_ABRK)
    else $error("maskable request granted while masked");

  boundary_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    svc_ack_ff |-> $past(cpu_boundary))
    else $error("grant away from instruction boundary");

  nmi_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && nmi_pend_ff) |=> vec_num_ff == VEC_NMI)
    else $error("lower priority served ahead of NMI");

  entry_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (svc_ack_ff && !wdt_overflow) |=> mem_req_ff.rd
      && mem_req_ff.addr == evp_vec_addr(vec_num_ff))
    else $error("vector entry address wrong");

  reserved_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
    svc_ack_ff |-> !(vec_num_ff inside {[6'h01:6'h06], 6'h13, 6'h14}))
    else $error("reserved vector granted");

  word_join_a: assert property (@(posedge clk) disable iff (!rst_n)
    pc_load_ff.load |-> pc_load_ff.target[7:0] == $past(mem_rdata)
      && pc_load_ff.target[15:8] == $past(mem_rdata, 2))
    else $error("vector word assembled wrong");

  wake_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wake_pend_ff) |-> $past(pins.wake_en))
    else $error("wakeup passed while disabled");

  trap_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    svc_ack_ff && vec_num_ff == VEC_TRAP0 ##4 pc_load_ff.load);
  wdt_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
    wdt_overflow ##5 pc_load_ff.load);
  nmi_over_ext_c: cover property (@(posedge clk) disable iff (!rst_n)
    take && nmi_pend_ff && ext_pend_ff[0]);
  masked_hold_c: cover property (@(posedge clk) disable iff (!rst_n)
    ccr_i_mask && cpu_boundary && |periph.serial2 && state_ff == EVP_IDLE);

endmodule // evp_prioritizer
`default_nettype wire

/* File: hdl/evp_pkg.sv */
// Constants, vector map and carrier types for the exception vector prioritizer.
// Assumes one system clock and a byte-wide vector memory with one cycle of read latency.
package evp_pkg;

  // Vector numbers, lowest number wins arbitration
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_NMI   = 6'h07;
  localparam logic [5:0] VEC_TRAP0 = 6'h08;
  localparam logic [5:0] VEC_ABRK  = 6'h0c;
  localparam logic [5:0] VEC_SLEEP = 6'h0d;
  localparam logic [5:0] VEC_EXT0  = 6'h0e;
  localparam logic [5:0] VEC_WAKE  = 6'h12;
  localparam logic [5:0] VEC_CMPT  = 6'h16;
  localparam logic [5:0] VEC_SER1  = 6'h17;
  localparam logic [5:0] VEC_TWB   = 6'h18;
  localparam logic [5:0] VEC_ADC   = 6'h19;
  localparam logic [5:0] VEC_MTU0  = 6'h1a;
  localparam logic [5:0] VEC_MTU1  = 6'h1b;
  localparam logic [5:0] VEC_RLD   = 6'h1d;
  localparam logic [5:0] VEC_SER2  = 6'h20;

  localparam int unsigned EVP_NVEC     = 33;
  localparam int unsigned EVP_NEXT     = 4;
  localparam int unsigned EVP_NWAKE    = 6;
  localparam logic [15:0] PC_RESET_VAL = 16'h0000;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;
  localparam logic [15:0] ADDR_NEXT_BYTE = 16'h0001;

  // Fetch sequencer
  typedef enum logic [2:0] {
    EVP_IDLE,
    EVP_ISSUE_HI,
    EVP_ISSUE_LO,
    EVP_TAKE_HI,
    EVP_TAKE_LO
  } evp_state_t;

  // Peripheral request levels, held by each peripheral until its flag is cleared
  typedef struct packed {
    logic [2:0] cmp_timer;   // Compare A, compare B, overflow
    logic [3:0] serial1;     // Rx full, tx empty, tx end, rx error
    logic [5:0] two_wire;    // Tx empty, tx end, rx full, arb/ovr, nack, stop
    logic       adc_end;
    logic [3:0] mtu_ch0;
    logic [3:0] mtu_ch1;
    logic       reload_ovf;
    logic [3:0] serial2;
  } evp_periph_req_t;

  // External and wakeup pins with their edge selects
  typedef struct packed {
    logic [3:0] ext;
    logic [3:0] ext_sel;
    logic [5:0] wake;
    logic [5:0] wake_sel;
    logic       wake_en;
  } evp_pins_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } evp_mem_req_t;

  typedef struct packed {
    logic        load;
    logic [15:0] target;
  } evp_pc_load_t;

  // Byte address of a vector entry: two bytes per vector
  function automatic logic [15:0] evp_vec_addr(input logic [5:0] vec);
    return {9'h000, vec, 1'b0};
  endfunction

endpackage

/* File: hdl/evp_edge_det.sv */
// Selectable edge detector for a group of interrupt pins.
// Assumes pins are already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module evp_edge_det #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] rise_sel,
  output logic      [W-1:0] edge_ff
);

  logic [W-1:0] prev_ff;
  logic         primed_ff;

  // Previous level; primed blocks a false edge on the first sample after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff   <= '0;
      primed_ff <= 1'b0;
    end else begin
      prev_ff   <= pin;
      primed_ff <= 1'b1;
    end
  end

  // Falling edge when select is 0, rising when 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_ff <= '0;
    end else begin
      edge_ff <= {W{primed_ff}} & ((rise_sel & pin & ~prev_ff)
                                  | (~rise_sel & ~pin & prev_ff));
    end
  end

endmodule // evp_edge_det
`default_nettype wire

/* File: testbench/evp_vec_mem_model.sv */
// Byte-wide vector memory that answers the fetch sequencer.
// Assumes reads are sampled on the rising edge and answered one cycle later.
`timescale 1ns/100ps
`default_nettype none

module evp_vec_mem_model
  import evp_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire evp_mem_req_t mem_req,
  output logic [7:0]        rdata_ff
);
  // Entry byte pattern; high and low differ so a swapped word shows up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (mem_req.rd) begin
      rdata_ff <= mem_req.addr[7:0] ^ 8'h5a;
    end else begin
      rdata_ff <= ~rdata_ff; // Stale data never lingers
    end
  end
endmodule // evp_vec_mem_model

`default_nettype wire

/* File: testbench/tb_exception_vector_prioritizer.sv */
// Self-checking bench for the exception vector prioritizer.
// Assumes the vector memory model; the bench plays core and peripherals.
`timescale 1ns/100ps
`default_nettype none

module tb_exception_vector_prioritizer
  import evp_pkg::*;
;
  logic            clk;
  logic            rst_n;
  logic            wdt_overflow;
  logic            cpu_boundary;
  logic            ccr_i_mask;
  logic            trap_exec;
  logic [1:0]      trap_num;
  logic            nmi_req;
  logic            addr_break_req;
  logic            sleep_direct_req;
  logic            low_voltage_req;
  evp_pins_t       pins;
  evp_periph_req_t periph;
  logic [7:0]      mem_rdata;
  evp_mem_req_t    mem_req_ff;
  evp_pc_load_t    pc_load_ff;
  logic [5:0]      vec_num_ff;
  logic            svc_ack_ff;
  logic            exc_busy_ff;
  logic            chip_reset_ff;
  int              errors;
  int              checked;
  int              cycles;

  evp_prioritizer evp_prioritizer_inst (
    .clk(clk), .rst_n(rst_n), .wdt_overflow(wdt_overflow), .cpu_boundary(cpu_boundary),
    .ccr_i_mask(ccr_i_mask), .trap_exec(trap_exec), .trap_num(trap_num), .nmi_req(nmi_req),
    .addr_break_req(addr_break_req), .sleep_direct_req(sleep_direct_req),
    .low_voltage_req(low_voltage_req), .pins(pins), .periph(periph), .mem_rdata(mem_rdata),
    .mem_req_ff(mem_req_ff), .pc_load_ff(pc_load_ff), .vec_num_ff(vec_num_ff),
    .svc_ack_ff(svc_ack_ff), .exc_busy_ff(exc_busy_ff), .chip_reset_ff(chip_reset_ff)
  );

  evp_vec_mem_model evp_vec_mem_model_inst (
    .clk(clk), .rst_n(rst_n), .mem_req(mem_req_ff), .rdata_ff(mem_rdata)
  );

  // 50 ns system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Drive point: a fixed delay after the rising edge
  task automatic tick();
    @(posedge clk);
    #5;
  endtask

  // Waits for the fetched word to be loaded as the new program counter
  task automatic wait_load(input logic [5:0] v);
    logic       got;
    logic [7:0] a;
    got = 1'b0;
    a = {1'b0, v, 1'b0};
    for (int i = 0; i < 12 && !got; i++) begin
      @(negedge clk);
      got = pc_load_ff.load;
    end
    check("pc_load", got, 1);
    check("busy_end", exc_busy_ff, 0);
    check("target", pc_load_ff.target, {a ^ 8'h5a, (a | 8'h01) ^ 8'h5a});
  endtask

  // Waits for a grant, checks its vector, then plays the peripheral clearing its flag
  task automatic expect_vec(input logic [5:0] v);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 60 && !got; i++) begin
      @(negedge clk);
      got = svc_ack_ff;
    end
    check("svc_ack", got, 1);
    check("vec_num", vec_num_ff, v);
    check("busy", exc_busy_ff, 1);
    tick();
    check("entry_req", {mem_req_ff.rd, mem_req_ff.addr}, {1'b1, 9'h000, v, 1'b0});
    case (v)
      VEC_CMPT: periph.cmp_timer = '0;
      VEC_SER1: periph.serial1 = '0;
      VEC_TWB:  periph.two_wire = '0;
      VEC_ADC:  periph.adc_end = 1'b0;
      VEC_MTU0: periph.mtu_ch0 = '0;
      VEC_MTU1: periph.mtu_ch1 = '0;
      VEC_RLD:  periph.reload_ovf = 1'b0;
      VEC_SER2: periph.serial2 = '0;
      default:  ;
    endcase
    wait_load(v);
  endtask

  // No grant may appear for n cycles
  task automatic expect_quiet(input int n);
    logic any;
    any = 1'b0;
    repeat (n) begin
      @(negedge clk);
      any = any | svc_ack_ff;
    end
    check("quiet", any, 0);
  endtask

  task automatic test_traps();
    for (int n = 0; n < 4; n++) begin
      tick();
      ccr_i_mask = 1'b1; // Traps must pass the mask
      trap_num = n[1:0];
      trap_exec = 1'b1;
      tick();
      trap_exec = 1'b0;
      expect_vec(VEC_TRAP0 + 6'(n));
    end
  endtask

  task automatic test_mask();
    tick();
    sleep_direct_req = 1'b1;
    periph.cmp_timer = 3'b010;
    tick();
    sleep_direct_req = 1'b0;
    expect_quiet(20);
    tick();
    addr_break_req = 1'b1;
    tick();
    addr_break_req = 1'b0;
    expect_vec(VEC_ABRK);
    tick();
    ccr_i_mask = 1'b0;
    expect_vec(VEC_SLEEP);
    expect_vec(VEC_CMPT);
  endtask

  task automatic test_boundary();
    tick();
    cpu_boundary = 1'b0;
    nmi_req = 1'b1;
    tick();
    nmi_req = 1'b0;
    expect_quiet(12);
    tick();
    cpu_boundary = 1'b1;
    expect_vec(VEC_NMI);
  endtask

  task automatic test_priority();
    tick();
    cpu_boundary = 1'b0;
    low_voltage_req = 1'b1;
    addr_break_req = 1'b1;
    periph = '{cmp_timer: 3'b100, serial1: 4'b0001, two_wire: 6'b100000, adc_end: 1'b1,
               mtu_ch0: 4'b0100, mtu_ch1: 4'b1000, reload_ovf: 1'b1, serial2: 4'b0010};
    tick();
    low_voltage_req = 1'b0;
    addr_break_req = 1'b0;
    tick();
    cpu_boundary = 1'b1;
    expect_vec(VEC_ABRK);
    expect_vec(VEC_EXT0);
    expect_vec(VEC_CMPT);
    expect_vec(VEC_SER1);
    expect_vec(VEC_TWB);
    expect_vec(VEC_ADC);
    expect_vec(VEC_MTU0);
    expect_vec(VEC_MTU1);
    expect_vec(VEC_RLD);
    expect_vec(VEC_SER2);
  endtask

  task automatic test_pins();
    tick();
    pins.ext = 4'b0110; // Wrong edge on the select 0 pin; the select 1 pin holds its level
    pins.wake[0] = 1'b0;
    expect_quiet(10);
    tick();
    pins.ext = 4'b0100;
    tick();
    pins.ext = 4'b0000;
    expect_vec(VEC_EXT0 + 6'd1);
    tick();
    pins.ext = 4'b0100;
    expect_vec(VEC_EXT0 + 6'd2);
    tick();
    pins.wake_en = 1'b1;
    pins.wake[0] = 1'b1;
    tick();
    pins.wake[0] = 1'b0;
    expect_vec(VEC_WAKE);
  endtask

  task automatic test_watchdog();
    tick();
    wdt_overflow = 1'b1;
    tick();
    wdt_overflow = 1'b0;
    check("chip_reset", chip_reset_ff, 1);
    wait_load(VEC_RESET);
    check("vec_wdt", vec_num_ff, VEC_RESET);
  endtask

  // Hang guard, well above the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    errors = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    wdt_overflow = 1'b0;
    cpu_boundary = 1'b1;
    ccr_i_mask = 1'b0;
    trap_exec = 1'b0;
    trap_num = 2'h0;
    nmi_req = 1'b0;
    addr_break_req = 1'b0;
    sleep_direct_req = 1'b0;
    low_voltage_req = 1'b0;
    pins = '{ext: 4'b0100, ext_sel: 4'b0100, wake: 6'h01, wake_sel: 6'h00, wake_en: 1'b0};
    periph = '0;
    repeat (16) @(posedge clk);
    #5;
    rst_n = 1'b1;
    tick();
    check("reset_fetch", {mem_req_ff.rd, mem_req_ff.addr}, {1'b1, ADDR_RESET});
    wait_load(VEC_RESET);
    check("vec_reset", vec_num_ff, VEC_RESET);
    test_traps();
    test_mask();
    test_boundary();
    test_priority();
    test_pins();
    test_watchdog();
    summarize();
  end
endmodule // tb_exception_vector_prioritizer

`default_nettype wire
